// ### rtl/ctm_cfg.svh
`ifndef CTM_CFG_SVH
`define CTM_CFG_SVH
// register byte addresses
`define CTM_ADDR_CTRL0     8'h00
`define CTM_ADDR_CTRL1     8'h04
`define CTM_ADDR_CNT_LO    8'h08
`define CTM_ADDR_CNT_HI    8'h0C
`define CTM_ADDR_CMPA_LO   8'h10
`define CTM_ADDR_CMPA_HI   8'h14
`define CTM_ADDR_PINEN     8'h18
`define CTM_ADDR_STATUS    8'h1C
// control 0 fields
`define CTM_C0_PAUSE       7
`define CTM_C0_CKS_HI      6
`define CTM_C0_CKS_LO      4
`define CTM_C0_RUN         3
`define CTM_C0_PER_HI      2
`define CTM_C0_PER_LO      0
// control 1 fields
`define CTM_C1_MODE_HI     7
`define CTM_C1_MODE_LO     6
`define CTM_C1_IO_HI       5
`define CTM_C1_IO_LO       4
`define CTM_C1_OC          3
`define CTM_C1_POL         2
`define CTM_C1_DPX         1
`define CTM_C1_CCLR        0
// pin function enable
`define CTM_PINEN_W        5
`define CTM_PIN_OUT1       2
// reset values
`define CTM_CTRL_RST       8'h00
`define CTM_PINEN_RST      5'h00
// prescaler taps
`define CTM_DIV4_BIT       1
`define CTM_DIV16_BIT      3
`define CTM_DIV64_BIT      5
// axi responses
`define CTM_RESP_OKAY      2'b00
`define CTM_RESP_SLVERR    2'b10
`endif

// ### rtl/ctm_pkg.sv
package ctm_pkg;
  typedef enum logic [2:0] {
    CKS_SYS_DIV4  = 3'h0,
    CKS_HIGH      = 3'h1,
    CKS_HIGH_D16  = 3'h2,
    CKS_HIGH_D64  = 3'h3,
    CKS_TBC_A     = 3'h4,
    CKS_TBC_B     = 3'h5,
    CKS_PIN_RISE  = 3'h6,
    CKS_PIN_FALL  = 3'h7
  } ctm_cks_t;
  typedef enum logic [1:0] {
    MODE_COMPARE  = 2'h0,
    MODE_UNDEF    = 2'h1,
    MODE_PWM      = 2'h2,
    MODE_COUNTER  = 2'h3
  } ctm_mode_t;
  typedef logic [9:0] ctm_count_t;
endpackage : ctm_pkg

// ### rtl/ctm_tick_gen.sv
`timescale 1ns/1ps
`include "ctm_cfg.svh"
module ctm_tick_gen (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // clock select
  input  wire ctm_pkg::ctm_cks_t cks,
  // clock sources, already on aclk
  input  wire logic              high_speed_tick,
  input  wire logic              timebase_tick,
  // external event pin, asynchronous
  input  wire logic              event_clock_pin,
  // one-cycle count enable
  output logic                   tick
);
  import ctm_pkg::*;

  logic [`CTM_DIV4_BIT:0] sys_div_ff;
  logic [5:0] high_div_ff;
  logic [2:0] pin_sync_ff;
  logic       sys_tap;
  logic       pin_rise;
  logic       pin_fall;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_div_ff <= '0;
    end else begin
      sys_div_ff <= sys_div_ff + 1'b1;
    end
  end

  // divide the high clock ticks by 16 and 64
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_div_ff <= 6'h00;
    end else if (high_speed_tick) begin
      high_div_ff <= high_div_ff + 6'h01;
    end
  end

  // two-stage synchroniser, third stage only for edge detect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sync_ff <= 3'h0;
    end else begin
      pin_sync_ff <= {pin_sync_ff[1:0], event_clock_pin};
    end
  end

  assign sys_tap  = &sys_div_ff[`CTM_DIV4_BIT:0];
  assign pin_rise = pin_sync_ff[1] & ~pin_sync_ff[2];
  assign pin_fall = ~pin_sync_ff[1] & pin_sync_ff[2];

  always_comb begin
    case (cks)
      CKS_SYS_DIV4: tick = sys_tap;
      CKS_HIGH:     tick = high_speed_tick;
      CKS_HIGH_D16: tick = high_speed_tick &
                           (&high_div_ff[`CTM_DIV16_BIT:0]);
      CKS_HIGH_D64: tick = high_speed_tick &
                           (&high_div_ff[`CTM_DIV64_BIT:0]);
      CKS_TBC_A,
      CKS_TBC_B:    tick = timebase_tick;
      CKS_PIN_RISE: tick = pin_rise;
      CKS_PIN_FALL: tick = pin_fall;
      default:      tick = 1'b0;
    endcase
  end
endmodule : ctm_tick_gen

// ### rtl/ctm_top.sv
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "ctm_cfg.svh"
// Overview of operation
// - up-counter compared with comparators; match may clear, set pin
// - three-bit clock select picks divided system, high, timebase or pin
// - two interrupt sources: compare-A match and period match
// - event pin drives the counter only when selected by clock select
// - pin clocking advances on rising or falling edge as configured
// - compare mode: output goes high, low or toggles on match
// - PWM mode: output pin carries the PWM waveform
// - pin enable bit 1 routes timer function to pin, 0 keeps other
// - enable register: out3 bit4, out2 bit3, out1 bit2, out0 bits 1,0
// - enable register bits 7 to 5 read as zero
// - low bytes go through shared 8-bit buffer, moved on high access
// - compare low byte write only fills the holding buffer
// - compare high byte write updates high, copies buffer to low
// - high byte read returns high, captures low byte into buffer
// - low byte read returns the holding buffer
// - three modes, one input pin, one output pin
// - 10-bit counter; period vs top three bits, compare-A vs all
// - counter clears on run rising, overflow or enabled match
// - clock select codes: sys/4, high, /16, /64, timebase x2, pin edges
module ctm_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // clock sources on aclk
  input  wire logic        high_speed_tick,
  input  wire logic        timebase_tick,
  // pins
  input  wire logic        event_clock_pin,
  output logic             timer_output_pin,
  output logic             timer_output_pin_en,
  output logic             event_clock_pin_sel,
  // pin function enables for the other timers
  output logic [4:0]       timer_pin_function_enable,
  // interrupt sources
  output logic             compare_a_match_pulse,
  output logic             period_match_pulse
);
  import ctm_pkg::*;

  logic [7:0]  ctrl0_ff;
  logic [7:0]  ctrl1_ff;
  logic [4:0]  pinen_ff;
  ctm_count_t  count_ff;
  ctm_count_t  compare_a_value_ff;
  logic [7:0]  hold_buf_ff;
  logic        run_d_ff;
  logic        out_ff;
  logic        cmpa_flag_ff;
  logic        per_flag_ff;
  logic        cmpa_pulse_ff;
  logic        per_pulse_ff;
  logic        aw_got_ff;
  logic        w_got_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;

  logic        tick;
  logic        run;
  logic        paused;
  logic        run_rise;
  logic [2:0]  period_compare_value;
  logic        match_a;
  logic        match_p;
  logic        overflow;
  logic        clear_cnt;
  logic        wr_do;
  logic        rd_do;
  logic        wr_lane0;
  logic [7:0]  wr_byte;
  logic        wr_map_ok;
  logic        rd_map_ok;
  logic [31:0] rd_word;
  ctm_cks_t    cks;
  ctm_mode_t   mode;
  logic [1:0]  io_sel;
  logic        oc;
  logic        pwm_level;
  ctm_count_t  nxt_count;
  logic        nxt_out;

  assign cks    = ctm_cks_t'(ctrl0_ff[`CTM_C0_CKS_HI:`CTM_C0_CKS_LO]);
  assign mode   = ctm_mode_t'(ctrl1_ff[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO]);
  assign io_sel = ctrl1_ff[`CTM_C1_IO_HI:`CTM_C1_IO_LO];
  assign oc     = ctrl1_ff[`CTM_C1_OC];
  assign run    = ctrl0_ff[`CTM_C0_RUN];
  assign paused = ctrl0_ff[`CTM_C0_PAUSE];
  assign period_compare_value = ctrl0_ff[`CTM_C0_PER_HI:`CTM_C0_PER_LO];

  ctm_tick_gen u_tick (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .cks             (cks),
    .high_speed_tick (high_speed_tick),
    .timebase_tick   (timebase_tick),
    .event_clock_pin (event_clock_pin),
    .tick            (tick)
  );

  // ---------------- counter and comparators ----------------
  assign run_rise = run & ~run_d_ff;
  // matches are qualified by a count step; compare-A is seen once, period match on each step while its top bits match
  assign match_a  = tick & run & ~paused &
                    (count_ff == compare_a_value_ff);
  assign match_p  = tick & run & ~paused &
                    (count_ff[9:7] == period_compare_value) &
                    (period_compare_value != 3'h0);
  assign overflow = tick & run & ~paused & (&count_ff);
  assign clear_cnt = overflow |
                     (ctrl1_ff[`CTM_C1_CCLR] ? match_a : match_p);

  always_comb begin
    nxt_count = count_ff;
    if (run_rise) begin
      nxt_count = '0;
    end else if (clear_cnt) begin
      nxt_count = '0;
    end else if (tick & run & ~paused) begin
      nxt_count = count_ff + 10'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_ff <= '0;
      run_d_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      run_d_ff <= run;
    end
  end

  // two interrupt sources, registered pulses on each matching count step plus sticky flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmpa_pulse_ff <= 1'b0;
      per_pulse_ff  <= 1'b0;
    end else begin
      cmpa_pulse_ff <= match_a;
      per_pulse_ff  <= match_p |
                       (overflow & (period_compare_value == 3'h0));
    end
  end
  assign compare_a_match_pulse = cmpa_pulse_ff;
  assign period_match_pulse    = per_pulse_ff;

  // ---------------- output pin ----------------
  // pwm: active while count below compare-A
  assign pwm_level = (count_ff < compare_a_value_ff) ? oc : ~oc;

  always_comb begin
    nxt_out = out_ff;
    case (mode)
      MODE_COMPARE: begin
        if (run_rise) begin
          nxt_out = oc;
        end else if (match_a) begin
          case (io_sel)
            2'h1:    nxt_out = 1'b0;
            2'h2:    nxt_out = 1'b1;
            2'h3:    nxt_out = ~out_ff;
            default: nxt_out = out_ff;
          endcase
        end
      end
      MODE_PWM: begin
        case (io_sel)
          2'h0:    nxt_out = ~oc;
          2'h1:    nxt_out = oc;
          2'h2:    nxt_out = run ? pwm_level : ~oc;
          default: nxt_out = out_ff;
        endcase
      end
      default: nxt_out = out_ff;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  assign timer_output_pin    = out_ff;
  assign timer_output_pin_en = pinen_ff[`CTM_PIN_OUT1];
  assign event_clock_pin_sel = (cks == CKS_PIN_RISE) |
                               (cks == CKS_PIN_FALL);
  assign timer_pin_function_enable = pinen_ff;

  // ---------------- axi4-lite write ----------------
  assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_got_ff & ~bvalid_ff;
  assign wr_do    = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign wr_lane0 = wr_do & wstrb_ff[0];
  assign wr_byte  = wdata_ff[7:0];

  always_comb begin
    case (awaddr_ff)
      `CTM_ADDR_CTRL0, `CTM_ADDR_CTRL1, `CTM_ADDR_CNT_LO,
      `CTM_ADDR_CNT_HI, `CTM_ADDR_CMPA_LO, `CTM_ADDR_CMPA_HI,
      `CTM_ADDR_PINEN, `CTM_ADDR_STATUS: wr_map_ok = 1'b1;
      default:                           wr_map_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= `CTM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_map_ok ? `CTM_RESP_OKAY : `CTM_RESP_SLVERR;
      end else if (bvalid_ff & s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // control and pin enable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_ff <= `CTM_CTRL_RST;
      ctrl1_ff <= `CTM_CTRL_RST;
      pinen_ff <= `CTM_PINEN_RST;
    end else if (wr_lane0) begin
      if (awaddr_ff == `CTM_ADDR_CTRL0) begin
        ctrl0_ff <= wr_byte;
      end
      if (awaddr_ff == `CTM_ADDR_CTRL1) begin
        ctrl1_ff <= wr_byte;
      end
      if (awaddr_ff == `CTM_ADDR_PINEN) begin
        pinen_ff <= wr_byte[`CTM_PINEN_W-1:0];
      end
    end
  end

  // compare-A pair behind the shared buffer; buffer also serves reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_a_value_ff <= '0;
      hold_buf_ff        <= 8'h00;
    end else begin
      if (wr_lane0 & (awaddr_ff == `CTM_ADDR_CMPA_LO)) begin
        hold_buf_ff <= wr_byte;
      end else if (rd_do & (s_axi_araddr == `CTM_ADDR_CNT_HI)) begin
        hold_buf_ff <= count_ff[7:0];
      end else if (rd_do & (s_axi_araddr == `CTM_ADDR_CMPA_HI)) begin
        hold_buf_ff <= compare_a_value_ff[7:0];
      end
      if (wr_lane0 & (awaddr_ff == `CTM_ADDR_CMPA_HI)) begin
        compare_a_value_ff <= {wr_byte[1:0], hold_buf_ff};
      end
    end
  end

  // ---------------- axi4-lite read ----------------
  assign s_axi_arready = ~rvalid_ff;
  assign rd_do = s_axi_arvalid & s_axi_arready;

  always_comb begin
    rd_word   = 32'h0000_0000;
    rd_map_ok = 1'b1;
    case (s_axi_araddr)
      `CTM_ADDR_CTRL0:   rd_word[7:0] = ctrl0_ff;
      `CTM_ADDR_CTRL1:   rd_word[7:0] = ctrl1_ff;
      `CTM_ADDR_CNT_LO:  rd_word[7:0] = hold_buf_ff;
      `CTM_ADDR_CNT_HI:  rd_word[1:0] = count_ff[9:8];
      `CTM_ADDR_CMPA_LO: rd_word[7:0] = hold_buf_ff;
      `CTM_ADDR_CMPA_HI: rd_word[1:0] = compare_a_value_ff[9:8];
      `CTM_ADDR_PINEN:   rd_word[4:0] = pinen_ff;
      `CTM_ADDR_STATUS:  rd_word[1:0] = {per_flag_ff, cmpa_flag_ff};
      default:           rd_map_ok    = 1'b0;
    endcase
  end

  // sticky match flags; status read clears, a new match wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmpa_flag_ff <= 1'b0;
      per_flag_ff  <= 1'b0;
    end else begin
      if (cmpa_pulse_ff) begin
        cmpa_flag_ff <= 1'b1;
      end else if (rd_do & (s_axi_araddr == `CTM_ADDR_STATUS)) begin
        cmpa_flag_ff <= 1'b0;
      end
      if (per_pulse_ff) begin
        per_flag_ff <= 1'b1;
      end else if (rd_do & (s_axi_araddr == `CTM_ADDR_STATUS)) begin
        per_flag_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `CTM_RESP_OKAY;
    end else if (rd_do) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= rd_map_ok ? `CTM_RESP_OKAY : `CTM_RESP_SLVERR;
    end else if (rvalid_ff & s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;
endmodule : ctm_top

// ### verif/ctm_top_monitor.sv
`timescale 1ns/1ps
`include "ctm_cfg.svh"
module ctm_top_monitor (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // timer side
  input wire logic        timer_output_pin_en,
  input wire logic [4:0]  timer_pin_function_enable,
  input wire logic        compare_a_match_pulse,
  input wire logic        period_match_pulse,
  input wire logic        event_clock_pin_sel
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  w_refuse_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write ready while response pending");
  r_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready while data pending");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read not answered next cycle");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  r_unmap_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > 8'h1c |=> s_axi_rresp == `CTM_RESP_SLVERR &&
    s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  rd_upper_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  pin_en_a: assert property (
    timer_output_pin_en == timer_pin_function_enable[`CTM_PIN_OUT1])
    else $error("output pin enable not following its bit");
  cover property (compare_a_match_pulse);
  cover property (period_match_pulse);
  cover property (event_clock_pin_sel && s_axi_rvalid);
endmodule : ctm_top_monitor

// ### verif/ctm_event_src.sv
`timescale 1ns/1ps
module ctm_event_src (
  // clock
  input wire logic       aclk,
  // request
  input wire logic       start,
  input wire logic [3:0] pulses,
  // pin and status
  output logic           event_clock_pin,
  output logic           busy
);
  logic [3:0] left_ff;
  logic [2:0] ph_ff;
  initial begin
    event_clock_pin = 1'b0;
    busy = 1'b0;
  end
  // pulses of four cycles high, four low; idle low between bursts
  always @(posedge aclk) begin
    if (start && !busy) begin
      left_ff <= pulses;
      ph_ff   <= 3'h0;
      busy    <= 1'b1;
    end else if (busy) begin
      ph_ff <= ph_ff + 3'h1;
      if (ph_ff == 3'h3) event_clock_pin <= 1'b1;
      if (ph_ff == 3'h7) begin
        event_clock_pin <= 1'b0;
        left_ff <= left_ff - 4'h1;
        if (left_ff == 4'h1) busy <= 1'b0;
      end
    end
  end
endmodule : ctm_event_src

// ### verif/ctm_top_tb_top.sv
`timescale 1ns/1ps
`include "ctm_cfg.svh"
`define CK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  bad_count++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
  end end
module ctm_top_tb_top;
  import ctm_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        high_speed_tick = 1'b0;
  logic        timebase_tick = 1'b0;
  logic        ev_start = 1'b0;
  logic [3:0]  ev_pulses = 4'h0;
  logic        ev_busy, event_clock_pin, timer_output_pin;
  logic        timer_output_pin_en, event_clock_pin_sel;
  logic        compare_a_match_pulse, period_match_pulse;
  logic [4:0]  timer_pin_function_enable;
  logic [1:0]  tb_div_ff = 2'h0;
  logic [1:0]  r;
  logic [31:0] d;
  logic [9:0]  v;
  logic        p0;
  logic [7:0]  c1s [3] = '{8'h31, 8'h19, 8'h21};
  int          waits [6] = '{40, 6, 160, 640, 40, 40};
  int          bad_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          t0, hc;

  ctm_top ctm_top_i (.*);
  ctm_event_src ctm_event_src_i (.aclk(aclk), .start(ev_start),
    .pulses(ev_pulses), .event_clock_pin(event_clock_pin), .busy(ev_busy));

  always #10 aclk = ~aclk;
  // timebase stands in at one tick every four cycles
  always @(posedge aclk) begin
    tb_div_ff <= tb_div_ff + 2'h1;
    timebase_tick <= (tb_div_ff == 2'h3);
    cyc <= cyc + 1;
  end

  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  task automatic guard(input int k);
    if (k >= 300) begin
      `CK(k, 0)
      tally_and_finish();
    end
  endtask : guard

  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    logic ad, wd;
    int   k;
    ad = 1'b0;
    wd = 1'b0;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h00_0000, dv};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awready && !ad) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !wd) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(ad && wd) && k < 300);
    do begin
      @(posedge aclk);
      k++;
    end while (!s_axi_bvalid && k < 300);
    guard(k);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
    end while (!s_axi_arready && k < 300);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      k++;
    end while (!s_axi_rvalid && k < 300);
    guard(k);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CK(d, e)
    `CK(r, `CTM_RESP_OKAY)
  endtask : chk_rd

  // high byte first so the low byte comes from the captured buffer
  task automatic rd_cnt();
    rd(8'h0c);
    v[9:8] = d[1:0];
    rd(8'h08);
    v[7:0] = d[7:0];
  endtask : rd_cnt

  task automatic wait_cmp();
    int k;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (!compare_a_match_pulse && k < 300);
    guard(k);
  endtask : wait_cmp

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rd(8'h18, 32'h0000_0000);
    chk_rd(8'h00, 32'h0000_0000);
    chk_rd(8'h04, 32'h0000_0000);
    wr(8'h18, 8'hff);
    chk_rd(8'h18, 32'h0000_001f);
    `CK(timer_pin_function_enable, 5'h1f)
    wr(8'h18, 8'h1b);
    `CK(timer_output_pin_en, 1'b0)
    wr(8'h18, 8'h04);
    `CK(timer_output_pin_en, 1'b1)
    `CK(timer_pin_function_enable, 5'h04)
    wr(8'h20, 8'h55);
    `CK(r, `CTM_RESP_SLVERR)
    rd(8'h20);
    `CK(r, `CTM_RESP_SLVERR)
    `CK(d, 32'h0000_0000)
    $display("test registers done");
    wr(8'h10, 8'h34);
    wr(8'h14, 8'h02);
    chk_rd(8'h10, 32'h0000_0034);
    wr(8'h10, 8'h56);
    chk_rd(8'h14, 32'h0000_0002);
    chk_rd(8'h10, 32'h0000_0034);
    $display("test byte buffer done");
    high_speed_tick <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, 8'h00);
      wr(8'h00, {1'b0, c[2:0], 4'h8});
      `CK(event_clock_pin_sel, 1'(c >= 6))
      if (c >= 6) begin
        ev_pulses <= 4'(c - 3);
        ev_start <= 1'b1;
        @(posedge aclk);
        ev_start <= 1'b0;
        @(posedge aclk);
        while (ev_busy) @(posedge aclk);
        repeat (6) @(posedge aclk);
      end else begin
        repeat (waits[c]) @(posedge aclk);
      end
      wr(8'h00, {1'b1, c[2:0], 4'h8});
      rd_cnt();
      if (c >= 6) `CK(v, 10'(c - 3))
      else `CK(v >= 10'h009 && v <= 10'h00d, 1'b1)
    end
    $display("test clock select done");
    wr(8'h10, 8'h05);
    wr(8'h14, 8'h00);
    for (int kk = 0; kk < 3; kk++) begin
      wr(8'h04, c1s[kk]);
      wr(8'h00, 8'h00);
      wr(8'h00, 8'h18);
      wait_cmp();
      t0 = cyc;
      repeat (2) @(posedge aclk);
      p0 = timer_output_pin;
      wait_cmp();
      `CK(cyc - t0, 6)
      repeat (2) @(posedge aclk);
      `CK(timer_output_pin, (kk == 0) ? ~p0 : 1'(kk == 2))
    end
    rd(8'h1c);
    `CK(d[0], 1'b1)
    $display("test compare output done");
    wr(8'h04, 8'ha8);
    wr(8'h00, 8'h00);
    wr(8'h00, 8'h18);
    hc = 0;
    repeat (1024) begin
      @(posedge aclk);
      hc += timer_output_pin;
    end
    `CK(hc >= 4 && hc <= 6, 1'b1)
    @(posedge aclk);
    `CK(period_match_pulse, 1'b1)
    rd(8'h1c);
    `CK(d[1], 1'b1)
    $display("test pwm done");
    tally_and_finish();
  end
endmodule : ctm_top_tb_top

bind ctm_top ctm_top_monitor ctm_top_monitor_i (.*);
